// ==== rtl/dancer_regs.svh ====
// Register offsets, reset values and codes of the dancer position supervisor
`ifndef DANCER_REGS_SVH
`define DANCER_REGS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define DRS_INSEL     8'h00
`define DRS_TARGET    8'h04
`define DRS_WINDOW    8'h08
`define DRS_UPPER     8'h0C
`define DRS_LOWER     8'h10
`define DRS_STAT      8'h14
`define DRS_FILT      8'h18
`define DRS_ACTION    8'h1C
`define DRS_MONSEL    8'h20
`define DRS_STATUS    8'h24
`define DRS_MONITOR   8'h28
`define DRS_IRQ_ST    8'h2C
`define DRS_IRQ_MASK  8'h30
`define DRS_CAL_BASE  8'h40
`define DRS_FUNC_BASE 8'h60
// ****************************************
// Reset values and codes
// ****************************************
`define DRS_INSEL_RST   3'h5
`define DRS_INSEL_T2    3'h3
`define DRS_INSEL_T6    3'h6
`define DRS_TARGET_RST  13'h1388
`define DRS_WINDOW_RST  10'h064
`define DRS_NONE        14'h270F
`define DRS_ACTION_RST  8'h28
`define DRS_ACT_REV     8'h28
`define DRS_ACT_FWD     8'h29
`define DRS_MON_POS     8'h1B
`define DRS_GAIN_RST    12'h3E8
`define DRS_FUNC_RST    8'hFF
`define DRS_POS_ZERO    16'sh1388
`define DRS_FULL_SCALE  25'sh00003E8
`define DRS_CODE_UP     8'h05
`define DRS_CODE_UP_N   8'h73
`define DRS_CODE_LO     8'h0E
`define DRS_CODE_LO_N   8'h72
`define DRS_CODE_LOSS   8'h32
`define DRS_CODE_LOSS_N 8'h96
`define DRS_CODE_WIN    8'h36
`define DRS_CODE_WIN_N  8'h9A
// ****************************************
// Timing
// ****************************************
`define DRS_CLK_HZ      100000000
`define DRS_FILT_STEP_US 1000
`define DRS_STAT_STEP_MS 10
`endif

// ==== rtl/dancer_pkg.sv ====
// Types shared by the dancer position supervisor
package dancer_pkg;
  typedef struct packed {
    logic signed [11:0] t2;
    logic signed [11:0] t4;
    logic signed [11:0] t1;
    logic signed [11:0] t6;
  } analog_s;
  typedef struct packed {
    logic loss;
    logic lower;
    logic upper;
    logic inWindow;
  } flags_s;
  typedef enum logic [1:0] {LOSS_IDLE, LOSS_TIMING, LOSS_TRIPPED} loss_e;
endpackage : dancer_pkg

// ==== rtl/dancer_lag_filter.sv ====
// First-order lag filter stepped once per millisecond tick
`timescale 1ns/1ns
module dancer_lag_filter
  import dancer_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               tick,
  input  wire logic signed [15:0] xIn,
  input  wire logic        [12:0] timeConst,
  output logic signed      [15:0] yOut
);
  logic signed [31:0] acc_r;
  logic signed [31:0] acc_nxt;
  logic signed [15:0] y_nxt;
  logic signed [31:0] div;
  logic        [12:0] tPrev_r;

  // Accumulator holds y*(T+1); no residue stalls short of the input
  always_comb begin
    div     = $signed({19'h00000, timeConst}) + 32'sh1;
    acc_nxt = acc_r;
    if (timeConst == 13'h0000) begin
      acc_nxt = 32'(xIn);
    end else if (timeConst != tPrev_r) begin
      // Rescale on a new time constant, else the output jumps and may trip the loss check
      acc_nxt = 32'(yOut) * div;
    end else if (tick) begin
      acc_nxt = acc_r + 32'(xIn) - 32'(yOut);
    end
    y_nxt = 16'(acc_nxt / div);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_r   <= 32'sh0;
      yOut    <= 16'sh0;
      tPrev_r <= 13'h0000;
    end else begin
      acc_r   <= acc_nxt;
      yOut    <= y_nxt;
      tPrev_r <= timeConst;
    end
  end
endmodule : dancer_lag_filter

// ==== rtl/dancer_out_map.sv ====
// Output terminal function mapping of the dancer flags
`timescale 1ns/1ns
`include "dancer_regs.svh"
module dancer_out_map
  import dancer_pkg::*;
#(
  parameter int NUM_OUT = 7
)(
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire flags_s                  flags,
  input  wire logic [NUM_OUT-1:0][7:0] funcCode,
  output logic      [NUM_OUT-1:0]      outTerm
);
  logic [NUM_OUT-1:0] out_nxt;

  function automatic logic mapCode(input logic [7:0] code, input flags_s f);
    case (code)
      `DRS_CODE_UP:     mapCode = f.upper;
      `DRS_CODE_UP_N:   mapCode = ~f.upper;
      `DRS_CODE_LO:     mapCode = f.lower;
      `DRS_CODE_LO_N:   mapCode = ~f.lower;
      `DRS_CODE_LOSS:   mapCode = f.loss;
      `DRS_CODE_LOSS_N: mapCode = ~f.loss;
      `DRS_CODE_WIN:    mapCode = f.inWindow;
      `DRS_CODE_WIN_N:  mapCode = ~f.inWindow;
      default:          mapCode = 1'b0;
    endcase
  endfunction : mapCode

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_term
    always_comb begin
      out_nxt[i] = mapCode(funcCode[i], flags);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      outTerm <= '0;
    end else begin
      outTerm <= out_nxt;
    end
  end
endmodule : dancer_out_map

// ==== rtl/dancer_position_supervision.sv ====
// Dancer roll position supervision: input select, calibration, filter, flags
// Function
// - Input select code 3,4,5,6 picks terminal 2, 4, 1 or 6; 5 default.
// - Target on offset scale: 6000 is +100, 5000 is 0, 4000 is -100 percent.
// - In-window flag while position minus target lies within detection level.
// - In-window flag routed by terminal code 54 high or 154 low.
// - At a limit longer than stationary time: malposition, PID compensation zero.
// - Stationary time 9999 disables signal loss detection entirely.
// - Resume PID only when motor stopped or shut off and start inactive.
// - Loss flag held during malposition; codes 50 high or 150 low.
// - First-order lag filter, 0 to 5 s in 1 ms steps; 0 bypasses.
// - Each terminal calibrated by its own bias and gain, 0 to 300 percent.
// - Upper flag when position exceeds upper limit; codes 5 or 115.
// - Lower flag when position below lower limit; codes 14 or 114.
// - Monitor shows dancer position when monitor select equals 27.
// - Restart after power failure inhibited while action select is 40 or 41.
// - Dancer control and winding compensation only while dancer enable asserted.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "dancer_regs.svh"
module dancer_position_supervision
  import dancer_pkg::*;
#(
  parameter int NUM_OUT   = 7,
  parameter int MS_CYCLES = `DRS_CLK_HZ / 1000000 * `DRS_FILT_STEP_US
)(
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wrData,
  input  wire logic               wrEn,
  input  wire logic               rdEn,
  output logic      [31:0]        rdData,
  input  wire analog_s            analog,
  input  wire logic               dancerEnable,
  input  wire logic               motorStopped,
  input  wire logic               outputShutoff,
  input  wire logic               startSignal,
  output logic      [NUM_OUT-1:0] outTerm,
  output logic                    pidZero,
  output logic                    dancerActive,
  output logic                    windingActive,
  output logic                    restartInhibit,
  output logic signed [15:0]      monitorValue,
  output logic                    irq
);
  if (NUM_OUT < 1 || NUM_OUT > 8 || MS_CYCLES < 2) begin : g_chk
    $error("dancer_position_supervision: bad parameter");
  end

  function automatic logic isDancer(input logic [7:0] act);
    isDancer = (act == `DRS_ACT_REV) || (act == `DRS_ACT_FWD);
  endfunction : isDancer

  // ****************************************
  // Settings registers
  // ****************************************
  logic        [2:0]         inselR_r,  inselR_nxt;
  logic        [12:0]        target_r,  target_nxt;
  logic        [9:0]         window_r,  window_nxt;
  logic        [13:0]        upper_r,   upper_nxt;
  logic        [13:0]        lower_r,   lower_nxt;
  logic        [13:0]        stat_r,    stat_nxt;
  logic        [12:0]        filt_r,    filt_nxt;
  logic        [7:0]         action_r,  action_nxt;
  logic        [7:0]         monsel_r,  monsel_nxt;
  logic        [3:0][11:0]   bias_r,    bias_nxt;
  logic        [3:0][11:0]   gain_r,    gain_nxt;
  logic [NUM_OUT-1:0][7:0]   func_r,    func_nxt;
  logic        [3:0]         mask_r,    mask_nxt;
  logic        [3:0]         irqSt_r,   irqSt_nxt;
  logic        [31:0]        rd_nxt;
  flags_s                    flags_r;
  flags_s                    flagsPrev_r;
  logic signed [15:0]        pos;

  always_comb begin
    inselR_nxt = inselR_r;
    target_nxt = target_r;
    window_nxt = window_r;
    upper_nxt  = upper_r;
    lower_nxt  = lower_r;
    stat_nxt   = stat_r;
    filt_nxt   = filt_r;
    action_nxt = action_r;
    monsel_nxt = monsel_r;
    bias_nxt   = bias_r;
    gain_nxt   = gain_r;
    func_nxt   = func_r;
    mask_nxt   = mask_r;
    if (wrEn) begin
      case (addr)
        `DRS_INSEL:    inselR_nxt = wrData[2:0];
        `DRS_TARGET:   target_nxt = wrData[12:0];
        `DRS_WINDOW:   window_nxt = wrData[9:0];
        `DRS_UPPER:    upper_nxt  = wrData[13:0];
        `DRS_LOWER:    lower_nxt  = wrData[13:0];
        `DRS_STAT:     stat_nxt   = wrData[13:0];
        `DRS_FILT:     filt_nxt   = wrData[12:0];
        `DRS_ACTION:   action_nxt = wrData[7:0];
        `DRS_MONSEL:   monsel_nxt = wrData[7:0];
        `DRS_IRQ_MASK: mask_nxt   = wrData[3:0];
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (addr == `DRS_CAL_BASE + 8'(8 * i)) begin
              bias_nxt[i] = wrData[11:0];
            end
            if (addr == `DRS_CAL_BASE + 8'(8 * i + 4)) begin
              gain_nxt[i] = wrData[11:0];
            end
          end
          for (int i = 0; i < NUM_OUT; i++) begin
            if (addr == `DRS_FUNC_BASE + 8'(4 * i)) begin
              func_nxt[i] = wrData[7:0];
            end
          end
        end
      endcase
    end
  end

  // Sticky events; a new event in the clearing cycle survives
  always_comb begin
    irqSt_nxt = irqSt_r;
    if (wrEn && addr == `DRS_IRQ_ST) begin
      irqSt_nxt = irqSt_r & ~wrData[3:0];
    end
    irqSt_nxt = irqSt_nxt | (flags_r & ~flagsPrev_r);
  end

  always_comb begin
    rd_nxt = 32'h0;
    case (addr)
      `DRS_INSEL:    rd_nxt = {29'h0, inselR_r};
      `DRS_TARGET:   rd_nxt = {19'h0, target_r};
      `DRS_WINDOW:   rd_nxt = {22'h0, window_r};
      `DRS_UPPER:    rd_nxt = {18'h0, upper_r};
      `DRS_LOWER:    rd_nxt = {18'h0, lower_r};
      `DRS_STAT:     rd_nxt = {18'h0, stat_r};
      `DRS_FILT:     rd_nxt = {19'h0, filt_r};
      `DRS_ACTION:   rd_nxt = {24'h0, action_r};
      `DRS_MONSEL:   rd_nxt = {24'h0, monsel_r};
      `DRS_STATUS:   rd_nxt = {28'h0, flags_r};
      `DRS_MONITOR:  rd_nxt = 32'(pos);
      `DRS_IRQ_ST:   rd_nxt = {28'h0, irqSt_r};
      `DRS_IRQ_MASK: rd_nxt = {28'h0, mask_r};
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (addr == `DRS_CAL_BASE + 8'(8 * i)) begin
            rd_nxt = {20'h0, bias_r[i]};
          end
          if (addr == `DRS_CAL_BASE + 8'(8 * i + 4)) begin
            rd_nxt = {20'h0, gain_r[i]};
          end
        end
        for (int i = 0; i < NUM_OUT; i++) begin
          if (addr == `DRS_FUNC_BASE + 8'(4 * i)) begin
            rd_nxt = {24'h0, func_r[i]};
          end
        end
      end
    endcase
    if (!rdEn) begin
      rd_nxt = 32'h0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      inselR_r <= `DRS_INSEL_RST;
      target_r <= `DRS_TARGET_RST;
      window_r <= `DRS_WINDOW_RST;
      upper_r  <= `DRS_NONE;
      lower_r  <= `DRS_NONE;
      stat_r   <= `DRS_NONE;
      filt_r   <= 13'h0000;
      action_r <= `DRS_ACTION_RST;
      monsel_r <= 8'h00;
      bias_r   <= '0;
      gain_r   <= {4{`DRS_GAIN_RST}};
      func_r   <= {NUM_OUT{`DRS_FUNC_RST}};
      mask_r   <= 4'h0;
      irqSt_r  <= 4'h0;
      rdData   <= 32'h0;
    end else begin
      inselR_r <= inselR_nxt;
      target_r <= target_nxt;
      window_r <= window_nxt;
      upper_r  <= upper_nxt;
      lower_r  <= lower_nxt;
      stat_r   <= stat_nxt;
      filt_r   <= filt_nxt;
      action_r <= action_nxt;
      monsel_r <= monsel_nxt;
      bias_r   <= bias_nxt;
      gain_r   <= gain_nxt;
      func_r   <= func_nxt;
      mask_r   <= mask_nxt;
      irqSt_r  <= irqSt_nxt;
      rdData   <= rd_nxt;
    end
  end

  assign irq = |(irqSt_r & mask_r);

  // ****************************************
  // Tick dividers
  // ****************************************
  logic [31:0] msCnt_r, msCnt_nxt;
  logic [3:0]  csCnt_r, csCnt_nxt;
  logic        msTick;
  logic        csTick;

  always_comb begin
    msTick    = (msCnt_r == 32'(MS_CYCLES - 1));
    msCnt_nxt = msTick ? 32'h0 : msCnt_r + 32'h1;
    csTick    = msTick && (csCnt_r == 4'(`DRS_STAT_STEP_MS - 1));
    csCnt_nxt = csCnt_r;
    if (msTick) begin
      csCnt_nxt = csTick ? 4'h0 : csCnt_r + 4'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      msCnt_r <= 32'h0;
      csCnt_r <= 4'h0;
    end else begin
      msCnt_r <= msCnt_nxt;
      csCnt_r <= csCnt_nxt;
    end
  end

  // ****************************************
  // Calibration and selection
  // ****************************************
  logic signed [3:0][11:0] raw;
  logic signed [15:0]      cal [4];
  logic signed [15:0]      selPos_r, selPos_nxt;

  assign raw = {analog.t6, analog.t1, analog.t4, analog.t2};

  for (genvar i = 0; i < 4; i++) begin : g_cal
    logic signed [12:0] span;
    logic signed [24:0] prod;
    always_comb begin
      span   = $signed({1'b0, gain_r[i]}) - $signed({1'b0, bias_r[i]});
      // Element select of a packed array is unsigned; negative samples need the cast
      prod   = 25'(span * $signed(raw[i]));
      cal[i] = $signed({4'h0, bias_r[i]}) + 16'(prod / `DRS_FULL_SCALE);
    end
  end

  // terminal pick, unknown codes fall back to terminal 1
  always_comb begin
    if (inselR_r >= `DRS_INSEL_T2 && inselR_r <= `DRS_INSEL_T6) begin
      selPos_nxt = `DRS_POS_ZERO + cal[2'(inselR_r - `DRS_INSEL_T2)];
    end else begin
      selPos_nxt = `DRS_POS_ZERO + cal[2];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      selPos_r <= `DRS_POS_ZERO;
    end else begin
      selPos_r <= selPos_nxt;
    end
  end

  // lag filter on the offset-scale position
  dancer_lag_filter u_filt (
    .mclk      (mclk),
    .rst       (rst),
    .tick      (msTick),
    .xIn       (selPos_r),
    .timeConst (filt_r),
    .yOut      (pos)
  );

  // ****************************************
  // Flags and malposition
  // ****************************************
  flags_s             flags_nxt;
  loss_e              loss_r, loss_nxt;
  logic [13:0]        statCnt_r, statCnt_nxt;
  logic signed [15:0] dev;
  logic               atLimit;
  logic               detOn;
  logic               resume;

  always_comb begin
    // target and position share the 4000-6000 scale
    dev = pos - $signed({3'h0, target_r});
    flags_nxt.inWindow = (dev <= $signed({6'h0, window_r}))
                      && (dev >= -$signed({6'h0, window_r}));
    flags_nxt.upper = (upper_r != `DRS_NONE) && (pos > $signed({2'h0, upper_r}));
    flags_nxt.lower = (lower_r != `DRS_NONE) && (pos < $signed({2'h0, lower_r}));
    flags_nxt.loss  = (loss_nxt == LOSS_TRIPPED);
  end

  always_comb begin
    atLimit = ((upper_r != `DRS_NONE) && (pos >= $signed({2'h0, upper_r})))
           || ((lower_r != `DRS_NONE) && (pos <= $signed({2'h0, lower_r})));
    // detection only when armed and dancer control on
    detOn   = (stat_r != `DRS_NONE) && dancerActive;
    resume  = (motorStopped || outputShutoff) && !startSignal;
    loss_nxt    = loss_r;
    statCnt_nxt = statCnt_r;
    case (loss_r)
      LOSS_IDLE: begin
        statCnt_nxt = 14'h0;
        if (detOn && atLimit) begin
          loss_nxt = LOSS_TIMING;
        end
      end
      LOSS_TIMING: begin
        if (!detOn || !atLimit) begin
          loss_nxt = LOSS_IDLE;
        end else if (statCnt_r > stat_r) begin
          loss_nxt = LOSS_TRIPPED;
        end else if (csTick) begin
          statCnt_nxt = statCnt_r + 14'h1;
        end
      end
      LOSS_TRIPPED: begin
        if (resume) begin
          loss_nxt = LOSS_IDLE;
        end
      end
      default: loss_nxt = LOSS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      loss_r      <= LOSS_IDLE;
      statCnt_r   <= 14'h0;
      flags_r     <= '0;
      flagsPrev_r <= '0;
    end else begin
      loss_r      <= loss_nxt;
      statCnt_r   <= statCnt_nxt;
      flags_r     <= flags_nxt;
      flagsPrev_r <= flags_r;
    end
  end

  dancer_out_map #(.NUM_OUT(NUM_OUT)) u_map (
    .mclk     (mclk),
    .rst      (rst),
    .flags    (flags_r),
    .funcCode (func_r),
    .outTerm  (outTerm)
  );

  // ****************************************
  // Control outputs and monitor
  // ****************************************
  logic signed [15:0] mon_nxt;

  always_comb begin
    mon_nxt = (monsel_r == `DRS_MON_POS) ? pos : 16'sh0;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      monitorValue   <= 16'sh0;
      dancerActive   <= 1'b0;
      windingActive  <= 1'b0;
      restartInhibit <= 1'b0;
      pidZero        <= 1'b0;
    end else begin
      monitorValue   <= mon_nxt;
      // enable input gates dancer and winding control
      dancerActive   <= dancerEnable && isDancer(action_r);
      windingActive  <= dancerEnable && isDancer(action_r);
      // no auto restart in dancer mode
      restartInhibit <= isDancer(action_r);
      // compensation forced to zero while tripped
      pidZero        <= (loss_nxt == LOSS_TRIPPED) || !dancerEnable;
    end
  end
endmodule : dancer_position_supervision

// ==== tb/dancer_sup_asserts.sv ====
// Port checks of the dancer position supervisor
`timescale 1ns/1ns
`include "dancer_regs.svh"
module dancer_sup_checker
  import dancer_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wrData,
  input wire logic        wrEn,
  input wire logic        rdEn,
  input wire logic [31:0] rdData,
  input wire logic        dancerEnable,
  input wire logic        pidZero,
  input wire logic        dancerActive,
  input wire logic        windingActive,
  input wire logic        restartInhibit,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ****************
  // Properties
  // ****************
  a_rd_idle: assert property (!$past(rdEn) |-> rdData == 32'h0)
    else $error("read data not idle");
  a_unmapped_zero: assert property ($past(rdEn) && $past(addr) == 8'h3C |-> rdData == 32'h0)
    else $error("unmapped read not zero");
  a_status_width: assert property ($past(rdEn) && $past(addr) == `DRS_STATUS |-> rdData[31:4] == 28'h0)
    else $error("status upper bits set");
  // Reset between write and check would reload action select 40 over the written value
  a_inhibit_act: assert property ($past(wrEn && addr == `DRS_ACTION, 3) && !$past(wrEn, 2) && !$past(wrEn)
      && !$past(rst) && !$past(rst, 2) |-> restartInhibit == ($past(wrData[7:0], 3) inside {8'h28, 8'h29}))
    else $error("restart inhibit wrong");
  a_winding_same: assert property (windingActive == dancerActive)
    else $error("winding differs from dancer");
  a_active_inhibit: assert property (dancerActive |-> restartInhibit)
    else $error("active without action 40 or 41");
  a_enable_off: assert property (!$past(dancerEnable) |-> !dancerActive)
    else $error("active while enable low");
  a_pid_off: assert property (!dancerEnable [*2] |-> pidZero)
    else $error("pid not zeroed");
  a_mask_quiet: assert property (wrEn && addr == `DRS_IRQ_MASK && wrData[3:0] == 4'h0 |=> !irq)
    else $error("irq while all masked");
  c_trip: cover property ($rose(pidZero) && dancerEnable);
  c_irq: cover property ($rose(irq));
  c_mon: cover property (rdEn && addr == `DRS_MONITOR);
endmodule : dancer_sup_checker

bind dancer_position_supervision dancer_sup_checker chk_u (.mclk, .rst, .addr, .wrData, .wrEn, .rdEn, .rdData,
  .dancerEnable, .pidZero, .dancerActive, .windingActive, .restartInhibit, .irq);

// ==== tb/dancer_sensor_model.sv ====
// Behavioural dancer roll sensor on the analog terminals
`timescale 1ns/1ns
module dancer_sensor_model
  import dancer_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               slow,
  input  wire logic signed [11:0] posCmd,
  output analog_s                 analog
);
  logic signed [11:0] pos = 12'sh000;
  // Slow mode drifts one step a cycle, as a real roll cannot jump
  always @(posedge mclk) begin
    if (!slow) begin
      pos <= posCmd;
    end else if (posCmd > pos) begin
      pos <= pos + 12'sh001;
    end else if (posCmd < pos) begin
      pos <= pos - 12'sh001;
    end
  end
  // Own offset per terminal so a wrong pick shows
  assign analog = '{t2: pos, t4: pos + 12'sh00A, t1: pos + 12'sh014, t6: pos + 12'sh01E};
endmodule : dancer_sensor_model

// ==== tb/test_dancer_position_supervision.sv ====
// Self-checking bench of the dancer position supervisor
`timescale 1ns/1ns
`include "dancer_regs.svh"
module test_dancer_position_supervision
  import dancer_pkg::*;
;
  logic mclk = 1'b0, rst = 1'b1, wrEn = 1'b0, rdEn = 1'b0, rdV = 1'b0, slow = 1'b0;
  logic dancerEnable = 1'b1, motorStopped = 1'b0, outputShutoff = 1'b0, startSignal = 1'b0;
  logic        [7:0]  addr = 8'h00;
  logic        [31:0] wrData = 32'h0;
  logic signed [11:0] posCmd = 12'sh000;
  logic        [31:0] rdData;
  analog_s            analog;
  logic        [6:0]  outTerm;
  logic               pidZero, dancerActive, windingActive, restartInhibit, irq;
  logic signed [15:0] monitorValue;
  logic        [31:0] expQ[$];
  int n_fail = 0, comparisons = 0, seed = 90, k, upL = 9999, loL = 9999;
  logic [7:0]  ra [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h44, 8'h60, 8'h3C};
  logic [31:0] rv [12] = '{32'h5, 32'h1388, 32'h64, 32'h270F, 32'h270F, 32'h270F, 32'h0, 32'h28, 32'h0,
                           32'h3E8, 32'hFF, 32'h0};
  dancer_position_supervision #(.NUM_OUT(7), .MS_CYCLES(10)) dut_u (.mclk, .rst, .addr, .wrData, .wrEn,
    .rdEn, .rdData, .analog, .dancerEnable, .motorStopped, .outputShutoff, .startSignal, .outTerm, .pidZero,
    .dancerActive, .windingActive, .restartInhibit, .monitorValue, .irq);
  dancer_sensor_model sen_u (.mclk, .slow, .posCmd, .analog);
  initial begin
    forever #5 mclk = ~mclk;
  end
  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge mclk);
    wrEn <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rdEn <= 1'b1;
    expQ.push_back(e);
    @(posedge mclk);
    rdEn <= 1'b0;
  endtask : rd
  // Flags worked out from target 4500, window 100 and the limits in force
  task automatic probe(input int raw);
    int pos;
    logic w, u, l;
    pos = 5000 + raw;
    w = (pos - 4500 <= 100) && (4500 - pos <= 100);
    u = (upL != 9999) && (pos > upL);
    l = (loL != 9999) && (pos < loL);
    @(posedge mclk);
    posCmd <= 12'(raw - 20);
    cyc(8);
    rd(`DRS_STATUS, {28'h0, 1'b0, l, u, w});
    @(negedge mclk);
    check({25'h0, outTerm}, {25'h0, 1'b0, ~l, l, ~u, u, ~w, w});
  endtask : probe
  task automatic wrap_up;
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  // ****************
  // Read data monitor and watchdog
  // ****************
  always @(posedge mclk) rdV <= rdEn;
  always @(negedge mclk) begin
    if (rdV && expQ.size() > 0) begin
      check(rdData, expQ.pop_front());
    end
  end
  initial begin
    cyc(20000);
    n_fail++;
    wrap_up;
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    cyc(6);
    rst <= 1'b0;
    for (k = 0; k < 12; k++) rd(ra[k], rv[k]);
    wr(`DRS_MONSEL, 32'h1B);
    posCmd <= 12'sh064;
    for (k = 3; k < 7; k++) begin
      wr(`DRS_INSEL, 32'(k));
      cyc(8);
      rd(`DRS_MONITOR, 32'(5100 + 10 * (k - 3)));
    end
    @(negedge mclk);
    check(32'(monitorValue), 32'h140A);
    wr(`DRS_MONSEL, 32'h0);
    cyc(4);
    @(negedge mclk);
    check(32'(monitorValue), 32'h0);
    wr(`DRS_INSEL, 32'h0);
    cyc(8);
    rd(`DRS_MONITOR, 32'h1400);
    wr(`DRS_INSEL, 32'h5);
    wr(8'h50, 32'h64);
    wr(8'h54, 32'h1F4);
    posCmd <= 12'sh1E0;
    cyc(8);
    rd(`DRS_MONITOR, 32'h14B4);
    posCmd <= -12'sh208;
    cyc(8);
    rd(`DRS_MONITOR, 32'h1324);
    wr(8'h50, 32'h0);
    wr(8'h54, 32'h3E8);
    wr(`DRS_TARGET, 32'h1194);
    wr(`DRS_UPPER, 32'h157C);
    wr(`DRS_LOWER, 32'h1194);
    upL = 5500;
    loL = 4500;
    for (k = 0; k < 7; k++) wr(8'(8'h60 + 4 * k), 32'({8'h32, 8'h72, 8'h0E, 8'h73, 8'h05, 8'h9A, 8'h36} >> (8 * k)));
    probe(-400);
    probe(-399);
    probe(-600);
    for (k = 0; k < 12; k++) probe($random(seed) % 1000);
    wr(`DRS_UPPER, 32'h270F);
    upL = 9999;
    probe(999);
    wr(`DRS_UPPER, 32'h157C);
    wr(`DRS_IRQ_MASK, 32'h8);
    posCmd <= 12'sh244;
    cyc(400);
    @(negedge mclk);
    check(32'(pidZero), 32'h0);
    wr(`DRS_STAT, 32'h2);
    cyc(150);
    @(negedge mclk);
    check(32'(pidZero), 32'h0);
    cyc(300);
    @(negedge mclk);
    check({29'h0, pidZero, outTerm[6], irq}, 32'h7);
    wr(`DRS_IRQ_MASK, 32'h0);
    @(negedge mclk);
    check(32'(irq), 32'h0);
    wr(`DRS_IRQ_MASK, 32'h8);
    @(negedge mclk);
    check(32'(irq), 32'h1);
    slow <= 1'b1;
    posCmd <= -12'sh014;
    cyc(700);
    outputShutoff <= 1'b1;
    startSignal <= 1'b1;
    cyc(20);
    @(negedge mclk);
    check(32'(pidZero), 32'h1);
    @(posedge mclk);
    startSignal <= 1'b0;
    cyc(5);
    @(negedge mclk);
    check({30'h0, pidZero, outTerm[6]}, 32'h0);
    wr(`DRS_IRQ_ST, 32'h8);
    @(negedge mclk);
    check(32'(irq), 32'h0);
    @(posedge mclk);
    dancerEnable <= 1'b0;
    outputShutoff <= 1'b0;
    cyc(3);
    @(negedge mclk);
    check({28'h0, pidZero, dancerActive, windingActive, restartInhibit}, 32'h9);
    wr(`DRS_ACTION, 32'h0);
    cyc(3);
    @(negedge mclk);
    check(32'(restartInhibit), 32'h0);
    wr(`DRS_ACTION, 32'h29);
    dancerEnable <= 1'b1;
    cyc(3);
    @(negedge mclk);
    check({29'h0, dancerActive, windingActive, restartInhibit}, 32'h7);
    wr(`DRS_MONSEL, 32'h1B);
    wr(`DRS_FILT, 32'h5);
    cyc(1500);
    rd(`DRS_MONITOR, 32'h1388);
    posCmd <= 12'sh244;
    cyc(3);
    @(negedge mclk);
    check(32'(monitorValue == 16'sh15E0), 32'h0);
    cyc(1500);
    rd(`DRS_MONITOR, 32'h15E0);
    @(negedge mclk);
    check(32'(pidZero), 32'h1);
    @(posedge mclk);
    motorStopped <= 1'b1;
    cyc(3);
    @(negedge mclk);
    check(32'(pidZero), 32'h0);
    cyc(4);
    wrap_up;
  end
endmodule : test_dancer_position_supervision
